// ==== hdl/lsch_handler.sv ====
// Purpose: Target-side handler for the log sense command.
// Assumes: CDB bytes arrive in order, one per cycle while cdb_ready_o is high.
// Notes:   Data-in bytes leave on a valid/ready handshake, then one status pulse.
`timescale 1ns/1ps
`default_nettype none
module lsch_handler (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cdb_valid_i,
  input wire logic [7:0] cdb_byte_i,
  output logic cdb_ready_o,
  input wire logic din_ready_i,
  output logic din_valid_o,
  output logic [7:0] din_data_o,
  output logic sts_valid_o,
  output logic sts_check_o,
  output logic [3:0] sense_key_o,
  output logic [7:0] asc_o,
  output logic save_pulse_o,
  input wire logic [lsch_pkg::N_CTR-1:0] ctr_event_i,
  input wire logic [lsch_pkg::CTR_W-1:0] list_value_i,
  input wire logic list_page_i,
  input wire logic clear_req_i,
  input wire logic [1:0] clear_psc_i,
  input wire logic counter_reset_bit_i
);
  import lsch_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Whole state of the handler; outputs are fields of it.
  typedef struct packed {
    lsch_state_e st; // Sequencer state.
    logic [3:0] cnt; // Index of the next CDB byte.
    logic [7:0] opc; // Captured operation code.
    logic save_req; // Captured save request bit.
    logic [1:0] psc; // Captured page select control.
    logic [5:0] page; // Page code, later the page being sent.
    logic [15:0] ptr; // Starting parameter code.
    logic [15:0] alloc; // Allocation length.
    logic [2:0] first; // First parameter sent from the counter page.
    logic [15:0] plen; // Page length field of the page being sent.
    logic [15:0] idx; // Index of the byte on the data-in port.
    logic [15:0] limit; // Bytes to send in this command.
    logic cdb_ready; // Ready for a CDB byte.
    logic din_valid; // Data-in byte is valid.
    logic [7:0] din_data; // Data-in byte.
    logic sts_valid; // Status pulse.
    logic sts_check; // Status is check condition.
    logic [3:0] key; // Sense key.
    logic [7:0] asc; // Additional sense code.
    logic save; // Save pulse.
  } lsch_hdl_s;

  localparam lsch_hdl_s HDL_RESET = '{st: ST_IDLE, cnt: 4'h0, opc: 8'h00,
    save_req: 1'b0, psc: 2'h0, page: 6'h00, ptr: 16'h0000, alloc: 16'h0000,
    first: 3'h0, plen: 16'h0000, idx: 16'h0000, limit: 16'h0000,
    cdb_ready: 1'b1, din_valid: 1'b0, din_data: 8'h00, sts_valid: 1'b0,
    sts_check: 1'b0, key: SK_NONE, asc: ASC_NONE, save: 1'b0};

  lsch_hdl_s q; // Registered state.
  lsch_hdl_s d; // Next state.

  // ----------------------------------------------------------------------
  // Counters of the counter page
  // ----------------------------------------------------------------------
  lsch_ctr_if ctr_bus [N_CTR] (); // One link per counter.
  logic [N_CTR-1:0] sat_vec; // Saturation of each counter.
  logic [N_PAR-1:0][CTR_W-1:0] par_val; // Values of every parameter.
  logic clr_all; // Clearing command for the current cumulative values.

  // A clear needs current cumulative control with the reset bit set.
  assign clr_all = clear_req_i && (clear_psc_i == PSC_CURRENT) && counter_reset_bit_i;
  // The list parameter is a binary value with no saturation handling.
  assign par_val[N_PAR-1] = list_value_i;

  // Each counter stops only for its own format and a neighbour's saturation.
  for (genvar g = 0; g < N_CTR; g++) begin : g_ctr
    assign ctr_bus[g].inc = ctr_event_i[g];
    assign ctr_bus[g].clr = clr_all;
    assign ctr_bus[g].stop = (PAR_FL[g] == FL_CTR_STOP) &&
      |(sat_vec & ~(N_CTR'(1) << g));
    assign sat_vec[g] = ctr_bus[g].sat;
    assign par_val[g] = ctr_bus[g].val;
    lsch_log_ctr u_ctr (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .bus(ctr_bus[g])
    );
  end

  // ----------------------------------------------------------------------
  // Command checks
  // ----------------------------------------------------------------------
  logic bad_opc; // Operation code is not log sense.
  logic bad_psc; // Page select control is not current cumulative.
  logic bad_page; // Requested page is not supported.
  logic cdb_done; // Final CDB byte is taken this cycle.

  // True when the page code is in the supported list.
  function automatic logic page_known(input logic [5:0] pg);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_SUP; i++) begin
      if (SUP_PAGES[i] == {2'b00, pg}) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign cdb_done = (q.st == ST_IDLE) && cdb_valid_i && (q.cnt == CDB_LAST);
  assign bad_opc = (q.opc != OPC_LOG_SENSE);
  assign bad_psc = (q.psc != PSC_CURRENT);
  // A list-format page is sent whatever the page code says.
  assign bad_page = !list_page_i && !page_known(q.page);

  // ----------------------------------------------------------------------
  // Log page byte generator
  // ----------------------------------------------------------------------
  // Returns byte k of the page being sent.
  function automatic logic [7:0] log_byte(input logic [5:0] pg,
      input logic [2:0] first, input logic [15:0] plen, input logic [15:0] k,
      input logic [N_PAR-1:0][CTR_W-1:0] vals);
    logic [15:0] off;
    logic [2:0] p;
    logic [2:0] b;
    logic [7:0] r;
    off = k - HDR_LEN;
    p = 3'(first + off[5:3]);
    b = off[2:0];
    r = 8'h00;
    if (k == 16'h0000) begin
      r = {2'b00, pg};
    end else if (k == 16'h0002) begin
      r = plen[15:8];
    end else if (k == 16'h0003) begin
      r = plen[7:0];
    end else if (k >= HDR_LEN) begin
      if (pg == PG_SUPPORTED) begin
        r = SUP_PAGES[off[4:0]];
      end else begin
        case (b)
          3'h1: r = {5'h00, p};
          3'h2: r = {CTRL_FIXED, PAR_FL[p]};
          3'h3: r = PAR_VAL_LEN;
          3'h4, 3'h5, 3'h6, 3'h7: r = 8'(vals[p] >> {3'h7 - b, 3'h0});
          default: r = 8'h00;
        endcase
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Collects the CDB, checks it, streams the page and reports status.
  always_comb begin
    logic [5:0] pg;
    logic [15:0] npar;
    logic [15:0] plen;
    logic [15:0] total;
    logic [15:0] lim;
    logic [15:0] nxt;
    pg = list_page_i ? PG_CTR : q.page;
    npar = (q.ptr > (N_PAR_W - 16'h0001)) ? 16'h0000 : N_PAR_W - q.ptr;
    plen = 16'h0000;
    nxt = q.idx + 16'h0001;
    total = 16'h0000;
    lim = 16'h0000;
    d = q;
    d.sts_valid = 1'b0;
    d.save = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (cdb_valid_i) begin
          // Capture the fields of interest by byte position.
          if (q.cnt == B_OPC) begin
            d.opc = cdb_byte_i;
          end else if (q.cnt == B_FLAGS) begin
            d.save_req = cdb_byte_i[SAVE_REQ_POS];
          end else if (q.cnt == B_PAGE) begin
            d.psc = cdb_byte_i[PSC_POS +: 2];
            d.page = cdb_byte_i[5:0];
          end else if (q.cnt == B_PTR_HI) begin
            d.ptr[15:8] = cdb_byte_i;
          end else if (q.cnt == B_PTR_LO) begin
            d.ptr[7:0] = cdb_byte_i;
          end else if (q.cnt == B_ALLOC_HI) begin
            d.alloc[15:8] = cdb_byte_i;
          end else if (q.cnt == B_ALLOC_LO) begin
            d.alloc[7:0] = cdb_byte_i;
          end
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == CDB_LAST) begin
            d.cnt = 4'h0;
            d.sts_check = 1'b0;
            d.key = SK_NONE;
            d.asc = ASC_NONE;
            if (bad_opc) begin
              // Wrong operation code: report and send nothing.
              d.sts_valid = 1'b1;
              d.sts_check = 1'b1;
              d.key = SK_ILLEGAL;
              d.asc = ASC_BAD_OPC;
            end else if (bad_psc || bad_page) begin
              // Bad field in the CDB: report and send nothing.
              d.sts_valid = 1'b1;
              d.sts_check = 1'b1;
              d.key = SK_ILLEGAL;
              d.asc = ASC_BAD_CDB;
            end else begin
              // Size the page and cap it by the allocation length.
              if (pg == PG_SUPPORTED) begin
                plen = SUP_LEN;
              end else if (pg == PG_CTR) begin
                plen = 16'(npar * PAR_LEN);
              end
              total = HDR_LEN + plen;
              lim = (total < q.alloc) ? total : q.alloc;
              d.save = q.save_req;
              d.page = pg;
              d.first = q.ptr[2:0];
              d.plen = plen;
              d.limit = lim;
              d.idx = 16'h0000;
              if (lim == 16'h0000) begin
                d.sts_valid = 1'b1;
              end else begin
                d.st = ST_SEND;
                d.cdb_ready = 1'b0;
                d.din_valid = 1'b1;
                d.din_data = log_byte(pg, q.ptr[2:0], plen, 16'h0000, par_val);
              end
            end
          end
        end
      end
      ST_SEND: begin
        if (din_ready_i) begin
          d.idx = nxt;
          if (nxt == q.limit) begin
            // Last byte taken: good status and back to idle.
            d.st = ST_IDLE;
            d.din_valid = 1'b0;
            d.din_data = 8'h00;
            d.cdb_ready = 1'b1;
            d.sts_valid = 1'b1;
          end else begin
            d.din_data = log_byte(q.page, q.first, q.plen, nxt, par_val);
          end
        end
      end
      default: begin
        d = HDL_RESET;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= HDL_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign cdb_ready_o = q.cdb_ready;
  assign din_valid_o = q.din_valid;
  assign din_data_o = q.din_data;
  assign sts_valid_o = q.sts_valid;
  assign sts_check_o = q.sts_check;
  assign sense_key_o = q.key;
  assign asc_o = q.asc;
  assign save_pulse_o = q.save;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_cdb_ok;
    cdb_done && !bad_opc && !bad_psc && !bad_page;
  endsequence

  sequence s_fail_status(logic [7:0] code);
    sts_valid_o && sts_check_o && sense_key_o == SK_ILLEGAL && asc_o == code &&
      !din_valid_o;
  endsequence

  a_opcode_reject: assert property (
    cdb_done && bad_opc |=> s_fail_status(ASC_BAD_OPC))
    else $error("Bad opcode not rejected.");
  a_psc_reject: assert property (
    cdb_done && !bad_opc && bad_psc |=> s_fail_status(ASC_BAD_CDB))
    else $error("Bad page select control not rejected.");
  a_page_reject: assert property (
    cdb_done && !bad_opc && !bad_psc && bad_page |=> s_fail_status(ASC_BAD_CDB))
    else $error("Unsupported page not rejected.");
  a_save_pulse: assert property (
    s_cdb_ok |=> save_pulse_o == $past(q.save_req))
    else $error("Save request not followed.");
  a_zero_alloc: assert property (
    s_cdb_ok ##0 (q.alloc == 16'h0000) |=> sts_valid_o && !sts_check_o && !din_valid_o)
    else $error("Zero allocation mishandled.");
  a_byte_cap: assert property (
    din_valid_o |-> q.idx < q.limit && q.limit <= q.alloc)
    else $error("Byte beyond allocation or page.");
  a_page_head: assert property (
    din_valid_o && q.idx == 16'h0000 |-> din_data_o == {2'b00, q.page})
    else $error("Page header code wrong.");
  a_ctrl_zero: assert property (
    din_valid_o && q.page == PG_CTR && q.idx >= HDR_LEN && q.idx[2:0] == 3'h6
      |-> din_data_o[7:2] == CTRL_FIXED)
    else $error("Control byte flags not zero.");
  a_list_len: assert property (
    din_valid_o && q.page == PG_SUPPORTED && q.idx == 16'h0003 |-> din_data_o == SUP_LEN[7:0])
    else $error("Supported list length wrong.");
  a_good_end: assert property (
    din_valid_o && din_ready_i && (q.idx + 16'h0001 == q.limit)
      |=> sts_valid_o && !sts_check_o ##1 !sts_valid_o && cdb_ready_o)
    else $error("Good status missing after transfer.");
endmodule // lsch_handler
`default_nettype wire

// ==== hdl/lsch_pkg.sv ====
// Purpose: Shared constants and types for the log sense command handler.
// Assumes: One 100 MHz clock, CDB bytes and data-in bytes move one per cycle.
// Notes:   Offsets, field positions, codes and the counter reset value live here.
`default_nettype none
package lsch_pkg;
  // ----------------------------------------------------------------------
  // Command descriptor block layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_LOG_SENSE = 8'h4d; // Operation code accepted.
  localparam logic [3:0] CDB_LAST = 4'h9; // Index of the final CDB byte.
  localparam logic [3:0] B_OPC = 4'h0; // Operation code byte.
  localparam logic [3:0] B_FLAGS = 4'h1; // Byte holding the save request bit.
  localparam logic [3:0] B_PAGE = 4'h2; // Page select control and page code.
  localparam logic [3:0] B_PTR_HI = 4'h5; // Start parameter pointer, high.
  localparam logic [3:0] B_PTR_LO = 4'h6; // Start parameter pointer, low.
  localparam logic [3:0] B_ALLOC_HI = 4'h7; // Allocation length, high.
  localparam logic [3:0] B_ALLOC_LO = 4'h8; // Allocation length, low.
  localparam int SAVE_REQ_POS = 0; // Save request bit position in byte 1.
  localparam int PSC_POS = 6; // Low bit of page select control in byte 2.
  localparam logic [1:0] PSC_CURRENT = 2'h1; // Current cumulative values.
  // ----------------------------------------------------------------------
  // Status and sense codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] SK_NONE = 4'h0; // Sense key for good status.
  localparam logic [3:0] SK_ILLEGAL = 4'h5; // Illegal request.
  localparam logic [7:0] ASC_NONE = 8'h00; // No additional sense.
  localparam logic [7:0] ASC_BAD_OPC = 8'h20; // Invalid operation code.
  localparam logic [7:0] ASC_BAD_CDB = 8'h24; // Invalid field in CDB.
  // ----------------------------------------------------------------------
  // Log page layout
  // ----------------------------------------------------------------------
  localparam logic [15:0] HDR_LEN = 16'h0004; // Page header bytes.
  localparam logic [15:0] PAR_LEN = 16'h0008; // Header plus value bytes.
  localparam logic [7:0] PAR_VAL_LEN = 8'h04; // Value bytes per parameter.
  localparam logic [5:0] CTRL_FIXED = 6'h00; // Update, save, threshold bits.
  localparam logic [5:0] PG_SUPPORTED = 6'h00; // Supported pages list.
  localparam logic [5:0] PG_CTR = 6'h02; // Page carrying the counters.
  localparam int N_SUP = 17; // Entries in the supported list.
  localparam logic [15:0] SUP_LEN = 16'h0011; // Length of the supported list.
  localparam logic [7:0] SUP_PAGES [N_SUP] = '{8'h00, 8'h02, 8'h03, 8'h05,
    8'h06, 8'h08, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h15, 8'h18, 8'h19, 8'h1a,
    8'h2f, 8'h30, 8'h37};
  // ----------------------------------------------------------------------
  // Parameters of the counter page
  // ----------------------------------------------------------------------
  localparam int CTR_W = 32; // Counter width.
  localparam int N_CTR = 4; // Counting parameters.
  localparam int N_PAR = 5; // Counters plus one binary list parameter.
  localparam logic [15:0] N_PAR_W = 16'h0005; // Same count, sized.
  localparam logic [CTR_W-1:0] CTR_RESET = 32'h0000_0000; // Cleared value.
  localparam logic [1:0] FL_CTR_STOP = 2'b00; // Stops on a page saturation.
  localparam logic [1:0] FL_ASCII = 2'b01; // ASCII list.
  localparam logic [1:0] FL_CTR_RUN = 2'b10; // Runs on past a page neighbour's saturation.
  localparam logic [1:0] FL_BIN = 2'b11; // Binary list.
  localparam logic [1:0] PAR_FL [N_PAR] = '{FL_CTR_STOP, FL_CTR_STOP,
    FL_CTR_RUN, FL_CTR_RUN, FL_BIN};
  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_SEND} lsch_state_e;
endpackage
`default_nettype wire

// ==== hdl/lsch_ctr_if.sv ====
// Purpose: Carries one log counter's controls and value between modules.
// Assumes: Driven and read on the single system clock.
// Notes:   The page side drives the controls, the counter drives the value.
`timescale 1ns/1ps
`default_nettype none
interface lsch_ctr_if;
  import lsch_pkg::*;
  logic inc; // Event to count.
  logic stop; // Hold the count because a page neighbour saturated.
  logic clr; // Reset to the cleared value.
  logic sat; // Counter sits at its maximum.
  logic [CTR_W-1:0] val; // Current count.
  modport ctr (input inc, input stop, input clr, output sat, output val);
  modport page (output inc, output stop, output clr, input sat, input val);
endinterface // lsch_ctr_if
`default_nettype wire

// ==== hdl/lsch_log_ctr.sv ====
// Purpose: One saturating log counter of the counter page.
// Assumes: Clear has priority over an event in the same cycle.
// Notes:   A stopped or saturated counter holds its value until cleared.
`timescale 1ns/1ps
`default_nettype none
module lsch_log_ctr (
  input wire logic mclk_i,
  input wire logic rst_i,
  lsch_ctr_if.ctr bus
);
  import lsch_pkg::*;

  // Whole state of the counter.
  typedef struct packed {
    logic [CTR_W-1:0] val;
  } lsch_ctr_s;

  lsch_ctr_s q; // Registered state.
  lsch_ctr_s d; // Next state.

  // The count is saturated once every bit is set.
  assign bus.sat = &q.val;
  assign bus.val = q.val;

  // Next-state logic: clear first, then a counted event.
  always_comb begin
    d = q;
    if (bus.clr) begin
      d.val = CTR_RESET;
    end else if (bus.inc && !bus.stop && !bus.sat) begin
      d.val = q.val + 32'h0000_0001;
    end
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{val: CTR_RESET};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_ctr_stop_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    bus.stop && !bus.clr |=> $stable(q.val))
    else $error("Stopped counter changed.");
  a_ctr_clear_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    bus.clr |=> q.val == CTR_RESET)
    else $error("Counter not cleared.");
  a_ctr_count_up: assert property (@(posedge mclk_i) disable iff (rst_i)
    bus.inc && !bus.stop && !bus.sat && !bus.clr |=> q.val == $past(q.val) + 1)
    else $error("Counter missed an event.");
endmodule // lsch_log_ctr
`default_nettype wire

// ==== testbench/lsch_init_model.sv ====
// Purpose: Initiator side that takes data-in bytes, promptly or slowly.
// Assumes: Ready moves only just after a rising edge.
// Notes:   Slow mode stalls at random.
`timescale 1ns/1ps
`default_nettype none
module lsch_init_model (
  input wire logic mclk_i,
  input wire logic slow_i,
  output var logic din_ready_o
);
  initial din_ready_o = 1'b0;
  // Takes every byte, or stalls at random while slow.
  always @(posedge mclk_i) begin
    din_ready_o <= slow_i ? 1'($urandom % 2) : 1'b1;
  end
endmodule // lsch_init_model
`default_nettype wire

// ==== testbench/log_sense_command_handler_bench.sv ====
// Purpose: Self-checking bench for the log sense command handler.
// Assumes: Inputs change at the falling edge, results sampled there too.
// Notes:   Expected bytes come from a queue model of the pages.
`timescale 1ns/1ps
`default_nettype none
module log_sense_command_handler_bench;
  import lsch_pkg::*;
  logic mclk_i = 0, rst_i = 1, cdb_valid = 0, din_ready, slow = 0, list_page = 0;
  logic clear_req = 0, crb = 0, cdb_ready, din_valid, sts_valid, sts_check, save_p;
  logic [1:0] clear_psc = 0;
  logic [3:0] ev = 0, skey;
  logic [7:0] cdb_byte = 0, din_data, asc;
  logic [31:0] list_val = 0;
  logic [12:0] sts_rec;
  logic save_rec, got_sts = 0;
  logic [7:0] got[$], exp[$];
  int n_errors = 0, num_checks = 0, cyc = 0, mc[4] = '{default: 0};
  localparam logic [12:0] GOOD = {1'b0, SK_NONE, ASC_NONE};
  localparam logic [12:0] BADCDB = {1'b1, SK_ILLEGAL, ASC_BAD_CDB};
  always #5 mclk_i = ~mclk_i;
  lsch_handler dut (.mclk_i(mclk_i), .rst_i(rst_i), .cdb_valid_i(cdb_valid),
    .cdb_byte_i(cdb_byte), .cdb_ready_o(cdb_ready), .din_ready_i(din_ready),
    .din_valid_o(din_valid), .din_data_o(din_data), .sts_valid_o(sts_valid),
    .sts_check_o(sts_check), .sense_key_o(skey), .asc_o(asc), .save_pulse_o(save_p),
    .ctr_event_i(ev), .list_value_i(list_val), .list_page_i(list_page),
    .clear_req_i(clear_req), .clear_psc_i(clear_psc), .counter_reset_bit_i(crb));
  lsch_init_model init_model (.mclk_i(mclk_i), .slow_i(slow), .din_ready_o(din_ready));
  // Records taken bytes and the status, and cuts a hang short.
  always @(negedge mclk_i) begin
    cyc++;
    if (din_valid === 1'b1 && din_ready === 1'b1) got.push_back(din_data);
    // The save pulse comes at command acceptance, before the status pulse, or with it when nothing is sent.
    if (save_p === 1'b1) save_rec = 1;
    if (sts_valid === 1'b1) begin
      got_sts = 1;
      sts_rec = {sts_check, skey, asc};
    end
    if (cyc > 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, e, s);
    end
  endtask
  // Builds the expected data-in bytes, cut to the allocation length.
  task automatic expect_pg(logic [7:0] pg, int ptr, int alloc);
    logic [7:0] b[$];
    logic [31:0] v;
    b = '{pg, 8'h00, 8'h00, 8'h00};
    if (pg == 8'h00) begin
      b[3] = 8'h11;
      foreach (SUP_PAGES[i]) b.push_back(SUP_PAGES[i]);
    end
    if (pg == 8'h02) for (int p = ptr; p < 5; p++) begin
      v = (p < 4) ? 32'(mc[p]) : list_val;
      b[3] += 8'h08;
      b.push_back(8'h00);
      b.push_back(8'(p));
      b.push_back({6'h00, PAR_FL[p]});
      b.push_back(8'h04);
      for (int k = 3; k >= 0; k--) b.push_back(v[8*k +: 8]);
    end
    exp.delete();
    for (int i = 0; i < b.size() && i < alloc; i++) exp.push_back(b[i]);
  endtask
  // Sends one ten-byte command and compares the outcome with the model.
  task automatic run(logic [7:0] opc, logic save_rq, logic [7:0] pg, logic [15:0] ptr,
      logic [15:0] alloc, logic [12:0] ests);
    logic [7:0] c[10];
    int t;
    c = '{opc, {7'h00, save_rq}, pg, 8'h00, 8'h00, ptr[15:8], ptr[7:0], alloc[15:8],
      alloc[7:0], 8'h00};
    got.delete();
    got_sts = 0;
    save_rec = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk_i);
      cdb_valid = 1;
      cdb_byte = c[i];
    end
    @(negedge mclk_i);
    cdb_valid = 0;
    t = 0;
    while (!got_sts && t < 3000) begin
      @(negedge mclk_i);
      #1;
      t++;
    end
    chk("status seen", 1, got_sts);
    chk("status", ests, sts_rec);
    chk("save", ests[12] ? 1'b0 : save_rq, save_rec);
    chk("count", exp.size(), got.size());
    foreach (exp[i]) if (i < got.size()) chk("byte", exp[i], got[i]);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    void'($urandom(10560));
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 0;
    chk("ready", 1, cdb_ready);
    foreach (SUP_PAGES[i]) begin
      slow = 1'($urandom % 2);
      list_val = $urandom;
      expect_pg(SUP_PAGES[i], 2 * (i % 4), i * 3);
      run(OPC_LOG_SENSE, i[0], {2'b01, SUP_PAGES[i][5:0]}, 16'(2 * (i % 4)), 16'(i * 3), GOOD);
    end
    expect_pg(8'h00, 0, 30);
    run(OPC_LOG_SENSE, 0, 8'h40, 16'h0003, 16'h001e, GOOD);
    expect_pg(8'h02, 7, 200);
    run(OPC_LOG_SENSE, 1, 8'h42, 16'h0007, 16'h00c8, GOOD);
    exp.delete();
    run(8'h4c, 1, 8'h40, 0, 16, {1'b1, SK_ILLEGAL, ASC_BAD_OPC});
    for (int k = 0; k < 4; k++) if (k != 1) run(8'h4d, 1, {2'(k), 6'h02}, 0, 16, BADCDB);
    run(8'h4d, 0, 8'h41, 0, 16, BADCDB);
    list_page = 1;
    expect_pg(8'h02, 0, 100);
    run(8'h4d, 0, 8'h41, 0, 100, GOOD);
    list_page = 0;
    for (int k = 0; k < 20; k++) begin
      @(negedge mclk_i);
      ev = 4'($urandom);
      foreach (mc[j]) mc[j] += ev[j];
    end
    @(negedge mclk_i);
    ev = 0;
    expect_pg(8'h02, 0, 200);
    run(8'h4d, 0, 8'h42, 0, 200, GOOD);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk_i);
      {clear_req, clear_psc, crb} = {1'b1, 2'(k), 1'b1};
      @(negedge mclk_i);
      clear_req = 0;
      if (k == 1) mc = '{default: 0};
      expect_pg(8'h02, 2 * k, 200);
      run(8'h4d, 0, 8'h42, 16'(2 * k), 200, GOOD);
    end
    give_verdict();
  end
endmodule // log_sense_command_handler_bench
`default_nettype wire
